// File: design/eipc_ext_chan.sv
// Purpose: One external interrupt channel with pin select and pending flag.
// Assumes: Pins arrive already synchronised to the system clock.
// Notes: Pending set by an edge beats a clear in the same cycle.
module eipc_ext_chan (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Pins and configuration
   input wire logic [eipc_pkg::PIN_N-1:0] pins_i,
   input wire eipc_pkg::eipc_ext_cfg_t cfg_i,
   // Core and software
   input wire logic vector_ack_i,
   input wire logic sw_write_i,
   input wire logic sw_value_i,
   output logic pending_o
);

   logic selected;
   logic active;
   logic active_reg;
   logic edge_hit;
   logic pending_reg;
   logic pending_next;

   // Polarity 0 means active low
   assign selected = pins_i[cfg_i.pin_sel]; // see RULE18
   assign active = cfg_i.polarity ? selected : ~selected; // see RULE10
   assign edge_hit = active & ~active_reg; // see RULE21
   assign pending_o = pending_reg;

   always_comb begin
      if (!cfg_i.edge_mode) begin
         pending_next = active; // see RULE15
      end else if (edge_hit) begin
         pending_next = 1'b1;
      end else if (vector_ack_i) begin
         pending_next = 1'b0; // see RULE14
      end else if (sw_write_i) begin
         pending_next = sw_value_i;
      end else begin
         pending_next = pending_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         active_reg <= 1'b0;
         pending_reg <= 1'b0;
      end else begin
         active_reg <= active;
         pending_reg <= pending_next;
      end
   end

endmodule

// File: design/eipc_pkg.sv
// Purpose: Shared constants and types of the extended interrupt slice.
// Assumes: Eight-bit register bus with a four-bit register page selector.
// Notes: Page and address pairs decide the priority and config hits; enable and timer control hits use the address alone.
package eipc_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PAGE_W = 4;
   localparam int PIN_N = 8;
   localparam int SEL_W = 3;
   localparam int EXT_N = 2;

   // ==========================================================
   // Register addresses and pages
   localparam logic [ADDR_W-1:0] ENABLE_TWO_ADDR = 8'hE7;
   localparam logic [ADDR_W-1:0] PRIORITY_TWO_ADDR = 8'hF7;
   localparam logic [ADDR_W-1:0] EXT_CONFIG_ADDR = 8'hDE;
   localparam logic [ADDR_W-1:0] TIMER_CTRL_ADDR = 8'hD8;
   localparam logic [PAGE_W-1:0] CONFIG_PAGE = 4'hF;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] ENABLE_TWO_RESET = 8'h00;
   localparam logic [DATA_W-1:0] PRIORITY_TWO_RESET = 8'h00;
   localparam logic [DATA_W-1:0] EXT_CONFIG_RESET = 8'h01;

   // ==========================================================
   // Source bit positions in the enable and priority banks
   localparam int TWOWIRE_BIT = 7;
   localparam int CAPSENSE_SCAN_END_BIT = 6;
   localparam int CAPSENSE_COMPARE_BIT = 5;
   localparam int CAPSENSE_DONE_BIT = 4;
   localparam int MULTIPLY_ACC_BIT = 3;
   localparam int RTC_OSC_FAIL_BIT = 2;
   localparam int PORT_MATCH_BIT = 1;
   localparam int SRC_LO = 1;

   // ==========================================================
   // External configuration register fields
   localparam int EXT_A_SEL_LSB = 0;
   localparam int EXT_A_POL_BIT = 3;
   localparam int EXT_B_SEL_LSB = 4;
   localparam int EXT_B_POL_BIT = 7;

   // ==========================================================
   // Timer control register interrupt bits
   localparam int EXT_A_EDGE_BIT = 0;
   localparam int EXT_A_PEND_BIT = 1;
   localparam int EXT_B_EDGE_BIT = 2;
   localparam int EXT_B_PEND_BIT = 3;

   // ==========================================================
   // Synchroniser depth
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } eipc_bus_req_t;

   typedef struct packed {
      logic [SEL_W-1:0] pin_sel;
      logic polarity;
      logic edge_mode;
   } eipc_ext_cfg_t;

endpackage

// File: design/eipc_sync.sv
// Purpose: Bring asynchronous pins into the system clock domain.
// Assumes: Inputs come from pins outside the clock domain.
// Notes: A bit changes only when the last two stages agree.
module eipc_sync #(
   parameter int WIDTH = 8,
   parameter int STAGES = eipc_pkg::SYNC_STAGES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Pins
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   if (STAGES < 3) begin : g_bad_stages
      $error("eipc_sync needs at least three stages");
   end

   logic [WIDTH-1:0] stage_reg [STAGES];
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] agree;

   assign agree = ~(stage_reg[STAGES-1] ^ stage_reg[STAGES-2]);
   assign sync_o = out_reg;

   always_ff @(posedge ref_clk_i) begin
      stage_reg[0] <= async_i;
   end

   for (genvar s = 1; s < STAGES; s++) begin : g_stage
      always_ff @(posedge ref_clk_i) begin
         stage_reg[s] <= stage_reg[s-1];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         // Pins idle high on their pull-ups: no false edge after reset
         out_reg <= '1;
      end else begin
         out_reg <= (agree & stage_reg[STAGES-1]) | (~agree & out_reg);
      end
   end

endmodule

// File: design/eipc_top.sv
// Purpose: Second extended interrupt enable and priority banks plus
//          the two external interrupt inputs with their pending flags.
// Assumes: Peripheral pending levels come from logic on ref_clk_i;
//          port 0 pins are asynchronous and are synchronised here.
// Notes: Requests to the core are registered, split by priority level.
//
// Contract
// RULE1: enable bit 7 gates two-wire slave requests.
// RULE2: enable bit 6 gates capacitive-sense end-of-scan requests.
// RULE3: enable bit 5 gates capacitive-sense comparator requests.
// RULE4: enable bit 4 gates capacitive-sense conversion-done requests.
// RULE5: enable bit 3 gates multiply-accumulate requests.
// RULE6: enable bit 2 gates RTC oscillator-fail requests.
// RULE7: enable bit 1 gates all port-match requests.
// RULE8: software writes bit 0 of both banks with its reset value.
// RULE9: priority bank at 0xF7 page 0xF, bit per source, resets zero.
// RULE10: each external input has a polarity bit, 1 active high.
// RULE11: type bit in timer control selects edge (1) or level (0).
// RULE12: external inputs watch a port pin without touching the crossbar.
// RULE13: two timer control flags are the external pending flags.
// RULE14: edge mode sets pending on edge, clears when core vectors.
// RULE15: level mode pending follows the active input level.
// RULE16: level source holds input active until request recognised.
// RULE17: level source releases input before its service routine ends.
// RULE18: three-bit pin select picks port 0 pin 0 to 7.
// RULE19: enable bank at 0xE7 on every page, resets zero.
// RULE20: request goes out when pending and enabled, level from priority.
// RULE21: pins synchronised before edge detection, one set per edge.
//
// The implementer's own choice: strobed register access.
module eipc_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Register bus
   input wire eipc_pkg::eipc_bus_req_t bus_i,
   output logic [eipc_pkg::DATA_W-1:0] rd_data_o,
   // Peripheral pending levels, bits 7 to 1
   input wire logic [eipc_pkg::DATA_W-1:eipc_pkg::SRC_LO] src_pending_i,
   // External interrupt pins and core side
   input wire logic [eipc_pkg::PIN_N-1:0] port0_i,
   input wire logic [eipc_pkg::EXT_N-1:0] ext_enable_i,
   input wire logic [eipc_pkg::EXT_N-1:0] ext_priority_i,
   input wire logic [eipc_pkg::EXT_N-1:0] ext_vector_ack_i,
   // Requests to the core
   output logic [eipc_pkg::DATA_W-1:eipc_pkg::SRC_LO] src_req_high_o,
   output logic [eipc_pkg::DATA_W-1:eipc_pkg::SRC_LO] src_req_low_o,
   output logic [eipc_pkg::EXT_N-1:0] ext_req_high_o,
   output logic [eipc_pkg::EXT_N-1:0] ext_req_low_o,
   output logic [eipc_pkg::EXT_N-1:0] ext_pending_o
);

   localparam int DW = eipc_pkg::DATA_W;
   localparam int LO = eipc_pkg::SRC_LO;
   localparam int EN = eipc_pkg::EXT_N;

   // ==========================================================
   // Register state
   logic [DW-1:0] extended_irq_enable_two_reg;
   logic [DW-1:0] extended_irq_enable_two_next;
   logic [DW-1:0] extended_irq_priority_two_reg;
   logic [DW-1:0] extended_irq_priority_two_next;
   logic [DW-1:0] ext_irq_config_reg;
   logic [DW-1:0] ext_irq_config_next;
   logic [EN-1:0] ext_edge_mode_reg;
   logic [EN-1:0] ext_edge_mode_next;
   logic [DW-1:0] rd_data_reg;
   logic [DW-1:0] rd_data_next;

   // ==========================================================
   // Request state
   logic [DW-1:LO] src_req_high_reg;
   logic [DW-1:LO] src_req_low_reg;
   logic [EN-1:0] ext_req_high_reg;
   logic [EN-1:0] ext_req_low_reg;
   logic [EN-1:0] ext_pending_reg;

   // ==========================================================
   // Address decode
   logic on_config_page;
   logic hit_enable;
   logic hit_priority;
   logic hit_config;
   logic hit_timer;
   logic wr_enable;
   logic wr_priority;
   logic wr_config;
   logic wr_timer;

   assign on_config_page = (bus_i.page == eipc_pkg::CONFIG_PAGE);
   assign hit_enable = (bus_i.addr == eipc_pkg::ENABLE_TWO_ADDR); // see RULE19
   assign hit_priority = on_config_page &&
      (bus_i.addr == eipc_pkg::PRIORITY_TWO_ADDR); // see RULE9
   assign hit_config = on_config_page &&
      (bus_i.addr == eipc_pkg::EXT_CONFIG_ADDR);
   assign hit_timer = (bus_i.addr == eipc_pkg::TIMER_CTRL_ADDR);

   assign wr_enable = bus_i.wr && hit_enable;
   assign wr_priority = bus_i.wr && hit_priority;
   assign wr_config = bus_i.wr && hit_config;
   assign wr_timer = bus_i.wr && hit_timer;

   // ==========================================================
   // Register write paths
   // Bit 0 of both banks is stored as written; software keeps it zero
   assign extended_irq_enable_two_next =
      wr_enable ? bus_i.wdata : extended_irq_enable_two_reg; // see RULE8
   assign extended_irq_priority_two_next =
      wr_priority ? bus_i.wdata : extended_irq_priority_two_reg;
   assign ext_irq_config_next = wr_config ? bus_i.wdata : ext_irq_config_reg;
   assign ext_edge_mode_next = wr_timer ?
      {bus_i.wdata[eipc_pkg::EXT_B_EDGE_BIT],
       bus_i.wdata[eipc_pkg::EXT_A_EDGE_BIT]} : ext_edge_mode_reg; // see RULE11

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         extended_irq_enable_two_reg <= eipc_pkg::ENABLE_TWO_RESET; // see RULE19
         extended_irq_priority_two_reg <= eipc_pkg::PRIORITY_TWO_RESET; // see RULE9
         ext_irq_config_reg <= eipc_pkg::EXT_CONFIG_RESET;
         ext_edge_mode_reg <= '0;
      end else begin
         extended_irq_enable_two_reg <= extended_irq_enable_two_next;
         extended_irq_priority_two_reg <= extended_irq_priority_two_next;
         ext_irq_config_reg <= ext_irq_config_next;
         ext_edge_mode_reg <= ext_edge_mode_next;
      end
   end

   // ==========================================================
   // Timer control image: edge mode and pending bits only
   logic [DW-1:0] timer_image;

   always_comb begin
      timer_image = '0;
      timer_image[eipc_pkg::EXT_A_EDGE_BIT] = ext_edge_mode_reg[0];
      timer_image[eipc_pkg::EXT_A_PEND_BIT] = ext_pending_reg[0]; // see RULE13
      timer_image[eipc_pkg::EXT_B_EDGE_BIT] = ext_edge_mode_reg[1];
      timer_image[eipc_pkg::EXT_B_PEND_BIT] = ext_pending_reg[1]; // see RULE13
   end

   // ==========================================================
   // Read path: data stands one cycle after the strobe, zero elsewhere
   logic [DW-1:0] read_mux;

   assign read_mux =
      hit_enable ? extended_irq_enable_two_reg :
      hit_priority ? extended_irq_priority_two_reg :
      hit_config ? ext_irq_config_reg :
      hit_timer ? timer_image : '0;
   assign rd_data_next = bus_i.rd ? read_mux : '0;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ==========================================================
   // External interrupt inputs
   logic [eipc_pkg::PIN_N-1:0] port0_sync;
   eipc_pkg::eipc_ext_cfg_t ext_cfg [EN];
   logic [EN-1:0] ext_pend_value;
   logic [EN-1:0] ext_pending;

   // Pins pass the synchroniser before any edge logic
   eipc_sync #(
      .WIDTH(eipc_pkg::PIN_N),
      .STAGES(eipc_pkg::SYNC_STAGES)
   ) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .async_i(port0_i),
      .sync_o(port0_sync)
   ); // see RULE21

   // Pins are only observed, so crossbar routing is unaffected
   assign ext_cfg[0].pin_sel =
      ext_irq_config_reg[eipc_pkg::EXT_A_SEL_LSB +: eipc_pkg::SEL_W]; // see RULE18
   assign ext_cfg[0].polarity = ext_irq_config_reg[eipc_pkg::EXT_A_POL_BIT]; // see RULE10
   assign ext_cfg[0].edge_mode = ext_edge_mode_reg[0];
   assign ext_cfg[1].pin_sel =
      ext_irq_config_reg[eipc_pkg::EXT_B_SEL_LSB +: eipc_pkg::SEL_W]; // see RULE18
   assign ext_cfg[1].polarity = ext_irq_config_reg[eipc_pkg::EXT_B_POL_BIT]; // see RULE10
   assign ext_cfg[1].edge_mode = ext_edge_mode_reg[1];
   assign ext_pend_value = {bus_i.wdata[eipc_pkg::EXT_B_PEND_BIT],
                            bus_i.wdata[eipc_pkg::EXT_A_PEND_BIT]};

   for (genvar e = 0; e < EN; e++) begin : g_ext
      // Edge sets, vector clears, level follows input
      eipc_ext_chan u_chan (
         .ref_clk_i(ref_clk_i),
         .reset_i(reset_i),
         .pins_i(port0_sync),
         .cfg_i(ext_cfg[e]),
         .vector_ack_i(ext_vector_ack_i[e]),
         .sw_write_i(wr_timer),
         .sw_value_i(ext_pend_value[e]),
         .pending_o(ext_pending[e])
      ); // see RULE12, see RULE14, see RULE15
   end

   // ==========================================================
   // Request qualification and priority split
   logic [DW-1:LO] src_active;
   logic [DW-1:LO] src_prio;
   logic [EN-1:0] ext_active;

   // Bits 7..1 mask two-wire, scan end, compare, done, MAC, RTC, match
   assign src_active = src_pending_i & // see RULE1, see RULE2, see RULE3, see RULE4
      extended_irq_enable_two_reg[DW-1:LO]; // see RULE5, see RULE6, see RULE7
   assign src_prio = extended_irq_priority_two_reg[DW-1:LO]; // see RULE9
   assign ext_active = ext_pending & ext_enable_i;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         src_req_high_reg <= '0;
         src_req_low_reg <= '0;
         ext_req_high_reg <= '0;
         ext_req_low_reg <= '0;
         ext_pending_reg <= '0;
      end else begin
         src_req_high_reg <= src_active & src_prio; // see RULE20
         src_req_low_reg <= src_active & ~src_prio; // see RULE20
         ext_req_high_reg <= ext_active & ext_priority_i; // see RULE20
         ext_req_low_reg <= ext_active & ~ext_priority_i; // see RULE20
         ext_pending_reg <= ext_pending;
      end
   end

   // ==========================================================
   // Outputs
   assign rd_data_o = rd_data_reg;
   assign src_req_high_o = src_req_high_reg;
   assign src_req_low_o = src_req_low_reg;
   assign ext_req_high_o = ext_req_high_reg;
   assign ext_req_low_o = ext_req_low_reg;
   assign ext_pending_o = ext_pending_reg;

endmodule

// File: verif/eipc_core_model.sv
// Purpose: Core side that vectors to the external routines.
// Assumes: One acknowledge pulse per seen request while auto is high.
// Notes: A quiet spell after each pulse lets the request fall first.
module eipc_core_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Requests and control
   input wire logic [1:0] req_i,
   input wire logic [1:0] auto_i,
   input wire logic [3:0] lag_i,
   // Vector acknowledge
   output logic [1:0] ack_o = 2'h0
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt [2];
   always @(posedge ref_clk_i) begin
      for (int c = 0; c < 2; c++) begin
         ack_o[c] <= !reset_i && auto_i[c] && cnt[c] == 13;
         if (reset_i || !auto_i[c]) begin
            cnt[c] <= 0;
         end else if (cnt[c] > 0) begin
            cnt[c] <= cnt[c] - 1;
         end else if (req_i[c]) begin
            cnt[c] <= lag_i + 14;
         end
      end
   end
endmodule

// File: verif/eipc_top_chk.sv
// Purpose: Port-level checks of the extended interrupt slice.
// Assumes: Register shadows are kept from bus writes.
// Notes: Only external channel a is watched for level mode.
module eipc_top_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Register bus
   input wire eipc_pkg::eipc_bus_req_t bus_i,
   input wire logic [7:0] rd_data_o,
   // Sources, pins and core
   input wire logic [7:1] src_pending_i,
   input wire logic [7:0] port0_i,
   input wire logic [1:0] ext_enable_i,
   input wire logic [1:0] ext_priority_i,
   input wire logic [1:0] ext_vector_ack_i,
   // Requests
   input wire logic [7:1] src_req_high_o,
   input wire logic [7:1] src_req_low_o,
   input wire logic [1:0] ext_req_high_o,
   input wire logic [1:0] ext_req_low_o,
   input wire logic [1:0] ext_pending_o
);
   // ==========
   // Register shadows
   logic [7:0] en_q, pri_q, cfg_q;
   logic [1:0] edge_q;
   wire pg_f = bus_i.page == eipc_pkg::CONFIG_PAGE;
   wire hit_en = bus_i.addr == eipc_pkg::ENABLE_TWO_ADDR;
   wire hit_pri = pg_f && bus_i.addr == eipc_pkg::PRIORITY_TWO_ADDR;
   wire hit_cfg = pg_f && bus_i.addr == eipc_pkg::EXT_CONFIG_ADDR;
   wire hit_tmr = bus_i.addr == eipc_pkg::TIMER_CTRL_ADDR;
   wire act_a = port0_i[cfg_q[2:0]] == cfg_q[3];
   wire clr_a = ext_vector_ack_i[0] || (bus_i.wr && hit_tmr);
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         en_q <= eipc_pkg::ENABLE_TWO_RESET;
         pri_q <= eipc_pkg::PRIORITY_TWO_RESET;
         cfg_q <= eipc_pkg::EXT_CONFIG_RESET;
         edge_q <= 2'h0;
      end else if (bus_i.wr) begin
         if (hit_en) en_q <= bus_i.wdata;
         if (hit_pri) pri_q <= bus_i.wdata;
         if (hit_cfg) cfg_q <= bus_i.wdata;
         if (hit_tmr) edge_q <= {bus_i.wdata[2], bus_i.wdata[0]};
      end
   end
   // ==========
   // Assertions
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_req_low_map: assert property (
      src_req_low_o == $past(src_pending_i & en_q[7:1] & ~pri_q[7:1]))
      else $error("low request mismatch");
   a_req_high_map: assert property (
      src_req_high_o == $past(src_pending_i & en_q[7:1] & pri_q[7:1]))
      else $error("high request mismatch");
   a_ext_req_split: assert property ({ext_req_high_o, ext_req_low_o} ==
      {ext_pending_o & $past(ext_enable_i & ext_priority_i),
      ext_pending_o & $past(ext_enable_i & ~ext_priority_i)}) else $error("ext request mismatch");
   a_rd_enable_val: assert property (
      bus_i.rd && hit_en |=> rd_data_o == $past(en_q)) else $error("enable read mismatch");
   a_rd_prio_val: assert property (
      bus_i.rd && hit_pri |=> rd_data_o == $past(pri_q)) else $error("priority read mismatch");
   a_rd_off_page: assert property (
      bus_i.rd && !pg_f && bus_i.addr == eipc_pkg::PRIORITY_TWO_ADDR |=> rd_data_o == 8'h00)
      else $error("priority seen off page");
   a_rd_timer_bits: assert property (bus_i.rd && hit_tmr |=>
      {rd_data_o[7:4], rd_data_o[2], rd_data_o[0]} == {4'h0, $past(edge_q)})
      else $error("timer control read mismatch");
   a_level_on: assert property (
      (act_a && !edge_q[0] && $stable(cfg_q)) [*8] |-> ext_pending_o[0])
      else $error("level flag missing");
   a_level_off: assert property (
      (!act_a && !edge_q[0] && $stable(cfg_q)) [*8] |-> !ext_pending_o[0])
      else $error("level flag stuck");
   a_edge_fall_cause: assert property (
      $fell(ext_pending_o[0]) && edge_q[0] && $past(edge_q[0], 3) |->
      $past(clr_a) || $past(clr_a, 2) || $past(clr_a, 3)) else $error("edge flag lost");
   c_edge_ack: cover property (ext_vector_ack_i[0] && edge_q[0] && ext_pending_o[0]);
   c_high_req: cover property (src_req_high_o != 7'h00);
   c_off_page: cover property (bus_i.rd && !pg_f && bus_i.addr == eipc_pkg::PRIORITY_TWO_ADDR);
endmodule
bind eipc_top eipc_top_chk u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i),
   .rd_data_o(rd_data_o), .src_pending_i(src_pending_i), .port0_i(port0_i),
   .ext_enable_i(ext_enable_i), .ext_priority_i(ext_priority_i),
   .ext_vector_ack_i(ext_vector_ack_i), .src_req_high_o(src_req_high_o),
   .src_req_low_o(src_req_low_o), .ext_req_high_o(ext_req_high_o),
   .ext_req_low_o(ext_req_low_o), .ext_pending_o(ext_pending_o));

// File: verif/tb.sv
// Purpose: Self-checking bench of the extended interrupt slice.
// Assumes: The core model acknowledges external requests on command.
// Notes: Random values come from a fixed seed.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   eipc_pkg::eipc_bus_req_t bus_i = '0;
   logic [7:1] src_pending_i = 7'h00;
   logic [7:0] port0_i = 8'hFF;
   logic [1:0] ext_enable_i = 2'h3;
   logic [1:0] ext_priority_i = 2'h0;
   logic [1:0] auto = 2'h0;
   logic [3:0] lag = 4'h0;
   logic [7:0] cfg_m = 8'h01;
   logic [7:0] tmr_m = 8'h00;
   logic [7:0] rd_data_o;
   logic [7:1] src_req_high_o, src_req_low_o;
   logic [1:0] ext_req_high_o, ext_req_low_o, ext_pending_o, ext_vector_ack_i;
   int err_total = 0;
   int n_checks = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   eipc_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
      .src_pending_i(src_pending_i), .port0_i(port0_i), .ext_enable_i(ext_enable_i),
      .ext_priority_i(ext_priority_i), .ext_vector_ack_i(ext_vector_ack_i),
      .src_req_high_o(src_req_high_o), .src_req_low_o(src_req_low_o),
      .ext_req_high_o(ext_req_high_o), .ext_req_low_o(ext_req_low_o),
      .ext_pending_o(ext_pending_o));
   eipc_core_model u_core (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .req_i(ext_req_high_o | ext_req_low_o), .auto_i(auto), .lag_i(lag),
      .ack_o(ext_vector_ack_i));
   // ==========
   // Bus and check tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      bus_i <= '{page: pg, addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      bus_i.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m, input string nm);
      @(posedge ref_clk_i);
      bus_i <= '{page: pg, addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus_i.rd <= 1'b0;
      #1;
      chk(nm, e & m, rd_data_o & m);
   endtask
   // Waits for the pending flag (w 0) or the acknowledge (w 1)
   task automatic wait_for(input int w, input int ch, input logic v);
      int k;
      k = 0;
      while ((w ? ext_vector_ack_i[ch] : ext_pending_o[ch]) !== v && k < 40) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      if ((w ? ext_vector_ack_i[ch] : ext_pending_o[ch]) !== v) begin
         err_total++;
         $display("wrong value wait %0d expected %h seen timeout", w, v);
         wrap_up;
      end
   endtask
   // ==========
   // One external channel run
   task automatic ext_run(input int ch, input logic [2:0] sel, input logic pol, input logic edg);
      logic [7:0] pins, m, tm;
      logic pr;
      pr = 1'($urandom);
      m = ch ? 8'hFD : 8'hF7;
      tm = eipc_pkg::TIMER_CTRL_ADDR;
      if (ch == 0) cfg_m[3:0] = {pol, sel};
      else cfg_m[7:4] = {pol, sel};
      tmr_m[2 * ch] = edg;
      pins = 8'($urandom);
      pins[sel] = ~pol;
      @(posedge ref_clk_i);
      port0_i <= pins;
      ext_priority_i[ch] <= pr;
      wr(4'hF, eipc_pkg::EXT_CONFIG_ADDR, cfg_m);
      wr(4'h5, tm, tmr_m);
      repeat (8) @(posedge ref_clk_i);
      wr(4'h0, tm, tmr_m);
      repeat (8) @(posedge ref_clk_i);
      rd(4'h0, tm, tmr_m, m, "idle flags");
      pins = 8'($urandom);
      pins[sel] = pol;
      @(posedge ref_clk_i);
      port0_i <= pins;
      wait_for(0, ch, 1'b1);
      chk("ext high", {7'h00, pr}, {7'h00, ext_req_high_o[ch]});
      chk("ext low", {7'h00, ~pr}, {7'h00, ext_req_low_o[ch]});
      rd(4'h0, tm, tmr_m | (8'h02 << (2 * ch)), m, "set flag");
      @(posedge ref_clk_i);
      ext_enable_i[ch] <= 1'b0;
      wr(4'h0, tm, tmr_m);
      if (edg) begin
         repeat (2) @(posedge ref_clk_i);
         #1;
         chk("soft clear", 8'h00, {7'h00, ext_pending_o[ch]});
         wr(4'h0, tm, tmr_m | (8'h02 << (2 * ch)));
      end
      repeat (6) @(posedge ref_clk_i);
      #1;
      chk("flag stands", 8'h01, {7'h00, ext_pending_o[ch]});
      chk("masked", 8'h00, {6'h00, ext_req_high_o[ch], ext_req_low_o[ch]});
      @(posedge ref_clk_i);
      ext_enable_i[ch] <= 1'b1;
      auto[ch] <= 1'b1;
      lag <= 4'($urandom);
      if (edg) begin
         wait_for(0, ch, 1'b0);
         repeat (8) @(posedge ref_clk_i);
         #1;
         chk("one set per edge", 8'h00, {7'h00, ext_pending_o[ch]});
      end else begin
         wait_for(1, ch, 1'b1);
         pins[sel] = ~pol;
         @(posedge ref_clk_i);
         port0_i <= pins;
         wait_for(0, ch, 1'b0);
      end
      @(posedge ref_clk_i);
      auto[ch] <= 1'b0;
   endtask
   // ==========
   // Main sequence
   initial begin
      logic [7:0] en, pr, pd;
      void'($urandom(37));
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(4'h0, eipc_pkg::ENABLE_TWO_ADDR, 8'h00, 8'hFF, "enable reset");
      rd(4'hF, eipc_pkg::PRIORITY_TWO_ADDR, 8'h00, 8'hFF, "priority reset");
      rd(4'hF, eipc_pkg::EXT_CONFIG_ADDR, 8'h01, 8'hFF, "config reset");
      rd(4'h0, eipc_pkg::TIMER_CTRL_ADDR, 8'h00, 8'hFF, "timer reset");
      for (int i = 0; i < 20; i++) begin
         en = (i < 7) ? (8'h02 << i) : (8'($urandom) & 8'hFE);
         pr = 8'($urandom) & 8'hFE;
         pd = (i < 7) ? 8'hFE : (8'($urandom) & 8'hFE);
         @(posedge ref_clk_i);
         src_pending_i <= pd[7:1];
         wr(4'($urandom), eipc_pkg::ENABLE_TWO_ADDR, en);
         wr(4'hF, eipc_pkg::PRIORITY_TWO_ADDR, pr);
         wr(4'h0, eipc_pkg::PRIORITY_TWO_ADDR, ~pr & 8'hFE);
         repeat (2) @(posedge ref_clk_i);
         #1;
         chk("req high", pd & en & pr, {src_req_high_o, 1'b0});
         chk("req low", pd & en & ~pr, {src_req_low_o, 1'b0});
         rd(4'($urandom), eipc_pkg::ENABLE_TWO_ADDR, en, 8'hFF, "enable");
         rd(4'hF, eipc_pkg::PRIORITY_TWO_ADDR, pr, 8'hFF, "priority");
         rd(4'h0, eipc_pkg::PRIORITY_TWO_ADDR, 8'h00, 8'hFF, "off page");
      end
      rd(4'hF, 8'h00, 8'h00, 8'hFF, "unmapped");
      for (int ch = 0; ch < 2; ch++) begin
         for (int s = 0; s < 8; s++) ext_run(ch, 3'(s), s[0], s[1]);
      end
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(4'h2, eipc_pkg::ENABLE_TWO_ADDR, 8'h00, 8'hFF, "enable again");
      rd(4'hF, eipc_pkg::EXT_CONFIG_ADDR, 8'h01, 8'hFF, "config again");
      wrap_up;
   end
endmodule
